// ==== tms_pkg.sv ====
// tms_pkg: constants, register map and carrier types for the timer mode select block.
// assumes a single 250 MHz system clock and a plain strobe-based register port.
package tms_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int CNT_W = 16;
   localparam int NUM_CH = 5;
   localparam int MODE_W = 8;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_MODE = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_SYNC = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_COMB = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_CH2_CNT = 4'h5;

   // ----------------------------------------------------------------
   // mode register fields and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] MODE_RST = 8'h80;
   localparam logic [7:0] MODE_WMASK = 8'h7F;
   localparam int MODE_RSV_BIT = 7;
   localparam int MODE_PHASE_BIT = 6;
   localparam int MODE_OVERFLOW_FLAG_DIRECTION_BIT = 5;
   localparam int CH0_SYNC_SELECT_BIT = 0;
   localparam int COMB_HI_BIT = 1;
   localparam int COMB_W = 2;
   localparam logic [COMB_W-1:0] COMB_RST = 2'h0;
   localparam int FIRST_COMB_CH = 3;

   // ----------------------------------------------------------------
   // interrupt status bits
   // ----------------------------------------------------------------
   localparam int IRQ_W = 2;
   localparam int IRQ_OVF_BIT = 0;
   localparam int IRQ_CH0_CLR_BIT = 1;
   localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

   localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [DATA_W-1:0] RDATA_ZERO = 16'h0000;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic we;
      logic re;
   } tms_bus_req_s;

   typedef struct packed {
      logic [NUM_CH-1:0] match_a;
      logic [NUM_CH-1:0] match_b;
   } tms_cmp_s;

endpackage

// ==== tms_top.sv ====
// tms_top: mode selection for a five channel timer, with the channel 2
// quadrature counter, per channel waveform pins and the channel 0 sync gate.
// assumes all inputs are synchronous to i_clk and compare matches are one-cycle pulses.
`timescale 1ns/1ps
module tms_top
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_standby,
   // register port
   input wire tms_pkg::tms_bus_req_s i_bus,
   output logic [tms_pkg::DATA_W-1:0] o_rdata,
   // channel 0 preset and clear sources
   input wire logic i_ch0_preset_own,
   input wire logic i_ch0_clear_own,
   input wire logic i_grp_preset,
   input wire logic i_grp_clear,
   output logic o_ch0_preset,
   output logic o_ch0_clear,
   // channel 2 counter
   input wire logic i_quad_input_a,
   input wire logic i_quad_input_b,
   input wire logic i_ch2_tick,
   input wire logic i_ch2_clear,
   output logic [tms_pkg::CNT_W-1:0] o_ch2_counter,
   // waveform pins and mode status
   input wire tms_pkg::tms_cmp_s i_cmp,
   output logic [tms_pkg::NUM_CH-1:0] o_pin_a,
   output logic [tms_pkg::NUM_CH-1:0] o_pin_a_oe,
   output logic [tms_pkg::COMB_W-1:0] o_combination_mode,
   // interrupt
   output logic o_irq
);
   import tms_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [MODE_W-1:0] mode_q;
   logic [MODE_W-1:0] mode_d;
   logic ch0_sync_select_q;
   logic ch0_sync_select_d;
   logic [COMB_W-1:0] comb_q;
   logic [COMB_W-1:0] comb_d;
   logic [IRQ_W-1:0] stat_q;
   logic [IRQ_W-1:0] stat_d;
   logic [IRQ_W-1:0] mask_q;
   logic [IRQ_W-1:0] mask_d;
   logic irq_q;
   logic irq_d;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic qa_q;
   logic qb_q;
   logic qa_d;
   logic qb_d;
   logic ch0_pre_q;
   logic ch0_pre_d;
   logic ch0_clr_q;
   logic ch0_clr_d;
   logic [NUM_CH-1:0] pin_q;
   logic [NUM_CH-1:0] pin_d;
   logic [NUM_CH-1:0] oe_q;
   logic [NUM_CH-1:0] oe_d;
   logic [IRQ_W-1:0] evt;
   logic init;

   // register write decode, used for every writable register
   function automatic logic wr_hit(input tms_bus_req_s b, input logic [ADDR_W-1:0] ofs);
      wr_hit = b.we && (b.addr == ofs);
   endfunction

   // waveform mode is effective unless the combination field owns channels 3 and 4
   function automatic logic pwm_on(input logic [MODE_W-1:0] m, input logic [COMB_W-1:0] c,
                                   input int ch);
      pwm_on = m[ch] && !(ch >= FIRST_COMB_CH && c[COMB_HI_BIT]);
   endfunction

   // standby initialises the configuration exactly like reset
   assign init = i_rst || i_standby;

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   // reserved mode bit is forced so a write can never clear it
   always_comb
   begin
      mode_d = mode_q;
      ch0_sync_select_d = ch0_sync_select_q;
      comb_d = comb_q;
      mask_d = mask_q;
      if (wr_hit(i_bus, OFS_MODE))
      begin
         mode_d = (i_bus.wdata[MODE_W-1:0] & MODE_WMASK) | MODE_RST;
      end
      if (wr_hit(i_bus, OFS_SYNC))
      begin
         ch0_sync_select_d = i_bus.wdata[CH0_SYNC_SELECT_BIT];
      end
      if (wr_hit(i_bus, OFS_COMB))
      begin
         comb_d = i_bus.wdata[COMB_W-1:0];
      end
      if (wr_hit(i_bus, OFS_IRQ_MASK))
      begin
         mask_d = i_bus.wdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (init)
      begin
         mode_q <= MODE_RST;
         ch0_sync_select_q <= 1'b0;
         comb_q <= COMB_RST;
         mask_q <= IRQ_RST;
      end
      else
      begin
         mode_q <= mode_d;
         ch0_sync_select_q <= ch0_sync_select_d;
         comb_q <= comb_d;
         mask_q <= mask_d;
      end
   end

   // ----------------------------------------------------------------
   // channel 0 preset and clear gating
   // ----------------------------------------------------------------
   // group sources only reach channel 0 while it is marked synchronous
   always_comb
   begin
      ch0_pre_d = i_ch0_preset_own || (ch0_sync_select_q && i_grp_preset);
      ch0_clr_d = i_ch0_clear_own || (ch0_sync_select_q && i_grp_clear);
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         ch0_pre_q <= 1'b0;
         ch0_clr_q <= 1'b0;
      end
      else
      begin
         ch0_pre_q <= ch0_pre_d;
         ch0_clr_q <= ch0_clr_d;
      end
   end

   // ----------------------------------------------------------------
   // channel 2 counter
   // ----------------------------------------------------------------
   // a transition on both pins in one cycle has no defined direction, so it is dropped
   always_comb
   begin
      logic a_ch;
      logic b_ch;
      logic step;
      logic up;
      a_ch = 1'b0;
      b_ch = 1'b0;
      step = 1'b0;
      up = 1'b1;
      evt = IRQ_RST;
      qa_d = i_quad_input_a;
      qb_d = i_quad_input_b;
      cnt_d = cnt_q;
      a_ch = i_quad_input_a ^ qa_q;
      b_ch = i_quad_input_b ^ qb_q;
      if (mode_q[MODE_PHASE_BIT])
      begin
         step = a_ch ^ b_ch;
         up = a_ch ? (i_quad_input_a == i_quad_input_b)
                   : (i_quad_input_a != i_quad_input_b);
      end
      else
      begin
         step = i_ch2_tick;
         up = 1'b1;
      end
      if (i_ch2_clear)
      begin
         cnt_d = CNT_ZERO;
      end
      else if (step && up)
      begin
         cnt_d = cnt_q + 16'h0001;
         evt[IRQ_OVF_BIT] = (cnt_q == CNT_MAX);
      end
      else if (step)
      begin
         cnt_d = cnt_q - 16'h0001;
         evt[IRQ_OVF_BIT] = (cnt_q == CNT_ZERO) && !mode_q[MODE_OVERFLOW_FLAG_DIRECTION_BIT];
      end
      evt[IRQ_CH0_CLR_BIT] = ch0_clr_d;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         cnt_q <= CNT_ZERO;
         qa_q <= 1'b0;
         qb_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         qa_q <= qa_d;
         qb_q <= qb_d;
      end
   end

   // ----------------------------------------------------------------
   // waveform pins
   // ----------------------------------------------------------------
   // a match on A wins over B in the same cycle, so a zero-width pulse reads high
   generate
      for (genvar ch = 0; ch < NUM_CH; ch++)
      begin : g_pin
         always_comb
         begin
            oe_d[ch] = pwm_on(mode_q, comb_q, ch);
            pin_d[ch] = pin_q[ch];
            if (!oe_d[ch])
            begin
               pin_d[ch] = 1'b0;
            end
            else if (i_cmp.match_a[ch])
            begin
               pin_d[ch] = 1'b1;
            end
            else if (i_cmp.match_b[ch])
            begin
               pin_d[ch] = 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clk)
   begin
      if (init)
      begin
         pin_q <= '0;
         oe_q <= '0;
      end
      else
      begin
         pin_q <= pin_d;
         oe_q <= oe_d;
      end
   end

   // ----------------------------------------------------------------
   // interrupt status and read port
   // ----------------------------------------------------------------
   // set wins over a write-one clear landing in the same cycle
   always_comb
   begin
      stat_d = stat_q;
      if (wr_hit(i_bus, OFS_IRQ_STAT))
      begin
         stat_d = stat_q & ~i_bus.wdata[IRQ_W-1:0];
      end
      stat_d = stat_d | evt;
      irq_d = |(stat_d & mask_d);
      rdata_d = RDATA_ZERO;
      if (i_bus.re)
      begin
         unique case (i_bus.addr)
            OFS_MODE: rdata_d[MODE_W-1:0] = mode_q | MODE_RST;
            OFS_SYNC: rdata_d[CH0_SYNC_SELECT_BIT] = ch0_sync_select_q;
            OFS_COMB: rdata_d[COMB_W-1:0] = comb_q;
            OFS_IRQ_STAT: rdata_d[IRQ_W-1:0] = stat_q;
            OFS_IRQ_MASK: rdata_d[IRQ_W-1:0] = mask_q;
            OFS_CH2_CNT: rdata_d = cnt_q;
            default: rdata_d = RDATA_ZERO;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         stat_q <= IRQ_RST;
         irq_q <= 1'b0;
         rdata_q <= RDATA_ZERO;
      end
      else
      begin
         stat_q <= stat_d;
         irq_q <= irq_d;
         rdata_q <= rdata_d;
      end
   end

   // outputs straight from flip-flops
   assign o_rdata = rdata_q;
   assign o_ch0_preset = ch0_pre_q;
   assign o_ch0_clear = ch0_clr_q;
   assign o_ch2_counter = cnt_q;
   assign o_pin_a = pin_q;
   assign o_pin_a_oe = oe_q;
   assign o_combination_mode = comb_q;
   assign o_irq = irq_q;

endmodule

// ==== tms_monitor.sv ====
// tms_monitor: port-level checks for the timer mode select block.
// assumes it is bound into tms_top and shares its single clock.
`timescale 1ns/1ps
module tms_monitor
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_standby,
   // register port
   input wire tms_pkg::tms_bus_req_s i_bus,
   input wire logic [tms_pkg::DATA_W-1:0] o_rdata,
   // channel 0 gating
   input wire logic i_ch0_preset_own,
   input wire logic i_ch0_clear_own,
   input wire logic i_grp_clear,
   input wire logic o_ch0_preset,
   input wire logic o_ch0_clear,
   // channel 2 counter
   input wire logic i_quad_input_a,
   input wire logic i_quad_input_b,
   input wire logic i_ch2_clear,
   input wire logic [tms_pkg::CNT_W-1:0] o_ch2_counter,
   // pins
   input wire tms_pkg::tms_cmp_s i_cmp,
   input wire logic [tms_pkg::NUM_CH-1:0] o_pin_a,
   input wire logic [tms_pkg::NUM_CH-1:0] o_pin_a_oe,
   input wire logic [tms_pkg::COMB_W-1:0] o_combination_mode
);
   import tms_pkg::*;
   logic [6:0] mode_q, mode_d;
   logic sync_q, sync_d, a_q, a_d, b_q, b_d;
   logic [CNT_W-1:0] step_v;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // shadow of the writable mode and sync bits; standby clears them like the design
   always_comb
   begin
      mode_d = mode_q;
      sync_d = sync_q;
      a_d = i_quad_input_a;
      b_d = i_quad_input_b;
      if (i_bus.we && i_bus.addr == OFS_MODE)
         mode_d = i_bus.wdata[6:0];
      if (i_bus.we && i_bus.addr == OFS_SYNC)
         sync_d = i_bus.wdata[0];
      if (i_rst || i_standby)
      begin
         mode_d = 7'h00;
         sync_d = 1'h0;
      end
   end
   always_ff @(posedge i_clk)
   begin
      mode_q <= mode_d;
      sync_q <= sync_d;
      a_q <= a_d;
      b_q <= b_d;
   end
   // expected step: a changed counts up when levels agree, b changed when they differ
   assign step_v = ((i_quad_input_a != a_q) ? (i_quad_input_a == i_quad_input_b)
      : (i_quad_input_a != i_quad_input_b)) ? 16'h0001 : 16'hFFFF;
   sequence s_mode_wr;
      i_bus.we && i_bus.addr == OFS_MODE && !i_standby;
   endsequence
   sequence s_one_edge;
      (i_quad_input_a != a_q) != (i_quad_input_b != b_q);
   endsequence
   property p_own;
      i_ch0_preset_own |=> o_ch0_preset;
   endproperty
   a_own: assert property (p_own) else $error("own preset lost");
   // with the sync bit off a group clear must never reach channel 0
   property p_indep;
      !sync_q && !i_ch0_clear_own |=> !o_ch0_clear;
   endproperty
   a_indep: assert property (p_indep) else $error("group clear leaked");
   property p_grp_sync;
      i_grp_clear && sync_q |=> o_ch0_clear;
   endproperty
   a_grp_sync: assert property (p_grp_sync) else $error("group clear lost");
   property p_stby;
      i_standby |=> o_pin_a_oe == 5'h00 && o_combination_mode == 2'h0;
   endproperty
   a_stby: assert property (p_stby) else $error("standby did not reset");
   property p_rsv;
      i_bus.re && i_bus.addr == OFS_MODE |=> o_rdata[7] && o_rdata[15:8] == 8'h00;
   endproperty
   a_rsv: assert property (p_rsv) else $error("mode top bit not one");
   property p_step;
      mode_q[6] && !i_ch2_clear ##0 s_one_edge |=>
         o_ch2_counter == $past(o_ch2_counter) + $past(step_v);
   endproperty
   a_step: assert property (p_step) else $error("bad quadrature step");
   property p_hold;
      mode_q[6] && !i_ch2_clear && i_quad_input_a == a_q && i_quad_input_b == b_q
         |=> $stable(o_ch2_counter);
   endproperty
   a_hold: assert property (p_hold) else $error("counter moved without edge");
   property p_oe;
      s_mode_wr ##1 !i_standby |=> o_pin_a_oe[2:0] == $past(i_bus.wdata[2:0], 2);
   endproperty
   a_oe: assert property (p_oe) else $error("pin enable wrong");
   property p_set;
      mode_q[0] && !i_standby && i_cmp.match_a[0] |=> o_pin_a[0];
   endproperty
   a_set: assert property (p_set) else $error("pin not set on match");
   property p_comb;
      o_combination_mode[1] && $past(o_combination_mode[1]) |-> o_pin_a_oe[4:3] == 2'h0;
   endproperty
   a_comb: assert property (p_comb) else $error("combination override lost");
endmodule
bind tms_top tms_monitor u_mon (.i_clk, .i_rst, .i_standby, .i_bus, .o_rdata,
   .i_ch0_preset_own, .i_ch0_clear_own, .i_grp_clear, .o_ch0_preset, .o_ch0_clear,
   .i_quad_input_a,
   .i_quad_input_b, .i_ch2_clear, .o_ch2_counter, .i_cmp, .o_pin_a, .o_pin_a_oe,
   .o_combination_mode);

// ==== tms_quad_enc.sv ====
// tms_quad_enc: behavioural quadrature encoder on the two count pins.
// assumes each step is started just after a rising clock edge.
`timescale 1ns/1ps
module tms_quad_enc
(
   // clock
   input wire logic i_clk,
   // encoder pins
   output logic o_a,
   output logic o_b
);
   int ph = 0;
   // gray order 00, 01, 11, 10 turns up; gap sets how slowly it turns
   task automatic step(input bit up, input int gap);
      ph = up ? (ph + 1) % 4 : (ph + 3) % 4;
      o_a <= ph[1];
      o_b <= ph[1] ^ ph[0];
      repeat (gap) @(posedge i_clk);
   endtask
   initial
   begin
      o_a = 1'h0;
      o_b = 1'h0;
   end
endmodule

// ==== timer_mode_select_logic_test.sv ====
// timer_mode_select_logic_test: directed register, pin and counter tests.
// assumes tms_quad_enc drives the quadrature pins.
`timescale 1ns/1ps
module timer_mode_select_logic_test;
   import tms_pkg::*;
   logic i_clk, i_rst, i_standby, i_ch2_tick, i_ch2_clear, qa, qb;
   logic o_ch0_preset, o_ch0_clear, o_irq;
   logic [3:0] ctl;
   tms_bus_req_s i_bus;
   tms_cmp_s i_cmp;
   logic [DATA_W-1:0] o_rdata;
   logic [CNT_W-1:0] o_ch2_counter;
   logic [NUM_CH-1:0] o_pin_a, o_pin_a_oe;
   logic [COMB_W-1:0] o_combination_mode;
   int n_mismatch = 0;
   int checked = 0;
   tms_quad_enc enc (.i_clk, .o_a(qa), .o_b(qb));
   tms_top uut (.i_clk, .i_rst, .i_standby, .i_bus, .o_rdata, .i_ch0_preset_own(ctl[3]),
      .i_ch0_clear_own(ctl[2]), .i_grp_preset(ctl[1]), .i_grp_clear(ctl[0]), .o_ch0_preset,
      .o_ch0_clear, .i_quad_input_a(qa), .i_quad_input_b(qb), .i_ch2_tick, .i_ch2_clear,
      .o_ch2_counter, .i_cmp, .o_pin_a, .o_pin_a_oe, .o_combination_mode, .o_irq);
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      i_bus <= '{a, d, 1'h1, 1'h0};
      @(posedge i_clk);
      i_bus.we <= 1'h0;
      @(posedge i_clk);
   endtask
   // read data stand only in the cycle after the strobe, so sample there
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      i_bus <= '{a, 16'h0000, 1'h0, 1'h1};
      @(posedge i_clk);
      i_bus.re <= 1'h0;
      #1 chk("rdata", o_rdata, e);
      @(posedge i_clk);
   endtask
   task automatic summarize;
      if (n_mismatch == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      i_clk = 1'h0;
      forever #2 i_clk = ~i_clk;
   end
   initial
   begin
      #20000;
      n_mismatch++;
      summarize();
   end
   initial
   begin
      i_rst = 1'h1;
      i_standby = 1'h0;
      i_bus = '0;
      i_cmp = '0;
      ctl = 4'h0;
      i_ch2_tick = 1'h0;
      i_ch2_clear = 1'h0;
      repeat (3) @(posedge i_clk);
      i_rst <= 1'h0;
      @(posedge i_clk);
      rd(OFS_MODE, 16'h0080);
      wr(OFS_MODE, 16'hFFFF);
      rd(OFS_MODE, 16'h00FF);
      wr(OFS_MODE, 16'h0000);
      rd(OFS_MODE, 16'h0080);
      rd(4'hF, 16'h0000);
      // every preset and clear source with the sync bit off and on
      for (int s = 0; s < 2; s++)
      begin
         wr(OFS_SYNC, 16'(s));
         for (int k = 0; k < 4; k++)
         begin
            ctl <= 4'h1 << k;
            @(posedge i_clk);
            ctl <= 4'h0;
            #1 chk("preset", o_ch0_preset, k == 3 || (k == 1 && s == 1));
            chk("clear", o_ch0_clear, k == 2 || (k == 0 && s == 1));
            @(posedge i_clk);
         end
      end
      // waveform pins, then combination codes 2, 3 and 0
      wr(OFS_MODE, 16'h001F);
      @(posedge i_clk);
      #1 chk("oe", o_pin_a_oe, 16'h001F);
      @(posedge i_clk);
      i_cmp <= '{5'h1F, 5'h00};
      @(posedge i_clk);
      i_cmp <= '{5'h00, 5'h0A};
      #1 chk("pin", o_pin_a, 16'h001F);
      @(posedge i_clk);
      i_cmp <= '0;
      #1 chk("pin", o_pin_a, 16'h0015);
      @(posedge i_clk);
      for (int c = 2; c < 5; c++)
      begin
         wr(OFS_COMB, 16'(c % 4));
         rd(OFS_COMB, 16'(c % 4));
         chk("comb", o_combination_mode, 16'(c % 4));
         #1 chk("oe", o_pin_a_oe, (c % 4) > 1 ? 16'h0007 : 16'h001F);
         @(posedge i_clk);
      end
      i_standby <= 1'h1;
      @(posedge i_clk);
      i_standby <= 1'h0;
      #1 chk("oe", o_pin_a_oe, 16'h0000);
      @(posedge i_clk);
      rd(OFS_MODE, 16'h0080);
      // quadrature counting with the plain tick held on, which must not count
      wr(OFS_IRQ_STAT, 16'h0003);
      wr(OFS_IRQ_MASK, 16'h0001);
      wr(OFS_MODE, 16'h0040);
      i_ch2_tick <= 1'h1;
      i_ch2_clear <= 1'h1;
      @(posedge i_clk);
      i_ch2_clear <= 1'h0;
      for (int k = 0; k < 3; k++)
         enc.step(1'b1, k + 1);
      @(posedge i_clk);
      #1 chk("count", o_ch2_counter, 16'h0003);
      @(posedge i_clk);
      for (int k = 0; k < 4; k++)
         enc.step(1'b0, 1);
      repeat (3) @(posedge i_clk);
      #1 chk("count", o_ch2_counter, 16'hFFFF);
      chk("irq", o_irq, 16'h0001);
      @(posedge i_clk);
      rd(OFS_IRQ_STAT, 16'h0001);
      wr(OFS_IRQ_STAT, 16'h0001);
      @(posedge i_clk);
      #1 chk("irq", o_irq, 16'h0000);
      @(posedge i_clk);
      wr(OFS_MODE, 16'h0060);
      enc.step(1'b1, 3);
      rd(OFS_IRQ_STAT, 16'h0001);
      wr(OFS_IRQ_STAT, 16'h0001);
      enc.step(1'b0, 3);
      rd(OFS_IRQ_STAT, 16'h0000);
      // back in normal mode the held tick counts again and wraps through zero
      wr(OFS_MODE, 16'h0000);
      repeat (2) @(posedge i_clk);
      i_ch2_tick <= 1'h0;
      rd(OFS_CH2_CNT, 16'h0002);
      rd(OFS_IRQ_STAT, 16'h0001);
      summarize();
   end
endmodule
